// >>> src/bce_exec.sv
// Execution unit: status read, increment and conditional jumps
//
// Our own choices: the placing of the registers and the Wishbone register port.
module bce_exec #(
    parameter int NREGS = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [bce_pkg::DATA_W-1:0] wb_dat_i,
    output logic [bce_pkg::DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    output logic busy,
    output logic [3:0] last_states
);
    import bce_pkg::*;

    // Instruction word register: written word at offset 0x08 issues it
    localparam logic [7:0] A_PC = 8'h00;
    localparam logic [7:0] A_ST = 8'h04;
    localparam logic [7:0] A_INSTR = 8'h08;
    localparam logic [7:0] A_CTRL = 8'h0c;
    localparam logic [7:0] A_REG0 = 8'h40;

    logic [DATA_W-1:0] pc_r;
    logic [DATA_W-1:0] st_r;
    logic [DATA_W-1:0] regs_r [NREGS];
    logic miss_r;
    logic ack_r;
    logic busy_r;
    logic [3:0] states_r;
    logic [15:0] op_r;
    logic [15:0] lo_r;
    bce_state_t state_r;

    logic req;
    logic wr;
    logic rd_reg;
    logic [3:0] ridx;
    logic [3:0] code;
    logic taken;
    logic [DATA_W-1:0] inc_sum;
    logic inc_n;
    logic inc_c;
    logic inc_z;
    logic inc_v;
    logic [15:0] w;
    logic is_jmp;
    logic is_abs;
    logic [DATA_W-1:0] pc_next;
    logic [3:0] pen;
    logic issue_w;

    assign req = wb_cyc_i && wb_stb_i && !ack_r;
    assign wr = req && wb_we_i && (wb_sel_i == 4'hf);
    assign rd_reg = wb_adr_i >= A_REG0 && wb_adr_i < A_REG0 + 8'(NREGS * 4);
    assign w = wb_dat_i[15:0];
    assign code = busy_r ? op_r[COND_MSB:COND_LSB] : w[COND_MSB:COND_LSB];
    assign is_jmp = w[15:12] == JMP_TOP;
    assign is_abs = is_jmp && w[ABS_BIT:0] == 8'h80;
    assign ridx = w[3:0];
    assign pc_next = pc_r + 32'(WORD_BITS);
    assign pen = miss_r ? MS_PENALTY : 4'h0;
    assign issue_w = wr && wb_adr_i == A_INSTR;
    assign busy = busy_r;
    assign last_states = states_r;

    // Flags read live from the status register, never a delayed copy
    bce_cond_eval u_cond (
        .code(code),
        .n(st_r[ST_N]),
        .c(st_r[ST_C]),
        .z(st_r[ST_Z]),
        .v(st_r[ST_V]),
        .taken(taken)
    );

    bce_inc_alu #(.W(DATA_W)) u_inc (
        .a(regs_r[ridx]),
        .sum(inc_sum),
        .n(inc_n),
        .c(inc_c),
        .z(inc_z),
        .v(inc_v)
    );

    // Bus answer: one ack per request, registered one cycle after the strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req;
        end
    end
    assign wb_ack_o = ack_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            if (wb_adr_i == A_PC) begin
                wb_dat_o <= pc_r;
            end else if (wb_adr_i == A_ST) begin
                wb_dat_o <= st_r;
            end else if (wb_adr_i == A_CTRL) begin
                wb_dat_o <= {25'h0, miss_r, 1'b0, busy_r, states_r};
            end else if (rd_reg) begin
                wb_dat_o <= regs_r[wb_adr_i[5:2]];
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            miss_r <= 1'b0;
        end else if (wr && wb_adr_i == A_CTRL) begin
            // Miss bit stands in for an uncached fetch: three extra states
            miss_r <= wb_dat_i[6];
        end
    end

    // Sequencer for instruction words and extension words
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= BCE_IDLE;
            busy_r <= 1'b0;
            op_r <= 16'h0000;
            lo_r <= 16'h0000;
            states_r <= 4'h0;
            pc_r <= PC_RESET;
            st_r <= ST_RESET;
        end else begin
            if (wr && wb_adr_i == A_PC) begin
                pc_r <= {wb_dat_i[31:4], 4'h0};
            end
            if (wr && wb_adr_i == A_ST) begin
                st_r <= wb_dat_i;
            end
            if (wr && wb_adr_i == A_INSTR) begin
                case (state_r)
                    BCE_IDLE: begin
                        if (w[15:5] == OP_RDST_HI) begin
                            pc_r <= pc_next;
                            states_r <= MS_SIMPLE + pen;
                        end else if (w[15:5] == OP_INC_HI) begin
                            pc_r <= pc_next;
                            st_r[ST_N] <= inc_n;
                            st_r[ST_C] <= inc_c;
                            st_r[ST_Z] <= inc_z;
                            st_r[ST_V] <= inc_v;
                            states_r <= MS_SIMPLE + pen;
                        end else if (is_abs || (is_jmp && w[7:0] == 8'h00)) begin
                            // Opcode kept; flags not touched by any jump
                            op_r <= w;
                            busy_r <= 1'b1;
                            pc_r <= pc_next;
                            state_r <= BCE_EXT1;
                        end else if (is_jmp) begin
                            if (taken) begin
                                // Offset scaled by 16 bits per word
                                pc_r <= pc_next + {{20{w[7]}}, w[7:0], 4'h0};
                                states_r <= MS_REL_T + pen;
                            end else begin
                                pc_r <= pc_next;
                                states_r <= MS_REL_N + pen;
                            end
                        end else begin
                            pc_r <= pc_next;
                        end
                    end
                    BCE_EXT1: begin
                        if (op_r[ABS_BIT]) begin
                            lo_r <= w;
                            pc_r <= pc_next;
                            state_r <= BCE_EXT2;
                        end else begin
                            busy_r <= 1'b0;
                            state_r <= BCE_IDLE;
                            if (taken) begin
                                pc_r <= pc_next + {{12{w[15]}}, w, 4'h0};
                                states_r <= MS_REL_T + pen;
                            end else begin
                                pc_r <= pc_next;
                                states_r <= MS_REL_N + pen;
                            end
                        end
                    end
                    BCE_EXT2: begin
                        busy_r <= 1'b0;
                        state_r <= BCE_IDLE;
                        if (taken) begin
                            pc_r <= {w, lo_r[15:4], 4'h0};
                            states_r <= MS_ABS_T + pen;
                        end else begin
                            pc_r <= pc_next;
                            states_r <= MS_ABS_N + pen;
                        end
                    end
                    default: begin
                        busy_r <= 1'b0;
                        state_r <= BCE_IDLE;
                    end
                endcase
            end
        end
    end

    // General registers: bus writes and instruction results
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < NREGS; i++) begin
                regs_r[i] <= 32'h0000_0000;
            end
        end else if (wr && rd_reg) begin
            regs_r[wb_adr_i[5:2]] <= wb_dat_i;
        end else if (wr && wb_adr_i == A_INSTR && state_r == BCE_IDLE) begin
            if (w[15:5] == OP_RDST_HI) begin
                regs_r[ridx] <= st_r;
            end else if (w[15:5] == OP_INC_HI) begin
                regs_r[ridx] <= inc_sum;
            end
        end
    end

    // Checks other than a_pc_aligned and a_abs_seq look at the word issued in that cycle; all but a_uc_taken also check the state it lands in
    a_pc_aligned: assert property (@(posedge clk) disable iff (reset)
        pc_r[3:0] == 4'h0) else $error("pc not word aligned");
    a_jump_flags: assert property (@(posedge clk) disable iff (reset)
        (wr && wb_adr_i == A_INSTR && (is_jmp || busy_r)) |=> $stable(st_r[31:28]))
        else $error("jump changed flags");
    a_uc_taken: assert property (@(posedge clk) disable iff (reset)
        (wr && wb_adr_i == A_INSTR && !busy_r && is_jmp && w[11:8] == CC_UC
         && w[7:0] != 8'h00 && !is_abs) |-> taken) else $error("uc not taken");
    a_rel_count: assert property (@(posedge clk) disable iff (reset)
        (wr && wb_adr_i == A_INSTR && !busy_r && is_jmp && !is_abs && w[7:0] != 8'h00
         && taken && !miss_r) |=> states_r == MS_REL_T) else $error("rel count");
    a_rel_target: assert property (@(posedge clk) disable iff (reset)
        (wr && wb_adr_i == A_INSTR && !busy_r && is_jmp && !is_abs && w[7:0] != 8'h00
         && taken) |=> pc_r == $past(pc_next) + {{20{$past(w[7])}}, $past(w[7:0]), 4'h0})
        else $error("rel target");
    a_rel_fall: assert property (@(posedge clk) disable iff (reset)
        (issue_w && !busy_r && is_jmp && !is_abs && w[7:0] != 8'h00 && !taken)
        |=> pc_r == $past(pc_next)) else $error("rel not taken target");
    a_inc_zero: assert property (@(posedge clk) disable iff (reset)
        (wr && wb_adr_i == A_INSTR && !busy_r && w[15:5] == OP_INC_HI
         && regs_r[ridx] == 32'hffff_ffff) |=> st_r[ST_Z] && st_r[ST_C])
        else $error("inc flags");
    a_inc_sum: assert property (@(posedge clk) disable iff (reset)
        (issue_w && state_r == BCE_IDLE && w[15:5] == OP_INC_HI)
        |=> regs_r[$past(ridx)] == $past(regs_r[ridx]) + 32'h1) else $error("inc sum");
    a_inc_count: assert property (@(posedge clk) disable iff (reset)
        (wr && wb_adr_i == A_INSTR && !busy_r && w[15:5] == OP_INC_HI)
        |=> states_r == MS_SIMPLE + $past(pen)) else $error("inc count");
    a_rdst_flags: assert property (@(posedge clk) disable iff (reset)
        (wr && wb_adr_i == A_INSTR && !busy_r && w[15:5] == OP_RDST_HI)
        |=> $stable(st_r)) else $error("status read changed status");
    a_abs_seq: assert property (@(posedge clk) disable iff (reset)
        (state_r == BCE_EXT2) |-> busy_r && op_r[ABS_BIT]) else $error("abs sequence");
    a_abs_target: assert property (@(posedge clk) disable iff (reset)
        (issue_w && state_r == BCE_EXT2 && taken)
        |=> pc_r == {$past(w), $past(lo_r[15:4]), 4'h0}) else $error("abs target");
    a_abs_fall: assert property (@(posedge clk) disable iff (reset)
        (issue_w && state_r == BCE_EXT2 && !taken)
        |=> pc_r == $past(pc_next)) else $error("abs not taken target");
    a_abs_count: assert property (@(posedge clk) disable iff (reset)
        (issue_w && state_r == BCE_EXT2 && !miss_r)
        |=> states_r == ($past(taken) ? MS_ABS_T : MS_ABS_N)) else $error("abs count");
    a_long_target: assert property (@(posedge clk) disable iff (reset)
        (issue_w && state_r == BCE_EXT1 && !op_r[ABS_BIT] && taken)
        |=> pc_r == $past(pc_next) + {{12{$past(w[15])}}, $past(w), 4'h0})
        else $error("long relative target");
    c_abs_taken: cover property (@(posedge clk) disable iff (reset)
        state_r == BCE_EXT2 && wr && wb_adr_i == A_INSTR && taken);
    c_rel_long: cover property (@(posedge clk) disable iff (reset)
        state_r == BCE_EXT1 && !op_r[ABS_BIT] && wr && wb_adr_i == A_INSTR);
    c_inc_ovf: cover property (@(posedge clk) disable iff (reset)
        wr && wb_adr_i == A_INSTR && w[15:5] == OP_INC_HI && inc_v);
    c_rel_fall: cover property (@(posedge clk) disable iff (reset)
        issue_w && !busy_r && is_jmp && !is_abs && w[7:0] != 8'h00 && !taken);
    c_abs_miss: cover property (@(posedge clk) disable iff (reset)
        issue_w && state_r == BCE_EXT2 && miss_r);
endmodule // bce_exec

// >>> src/bce_pkg.sv
// Package: constants for the branch/condition execution block
package bce_pkg;
    localparam int DATA_W = 32;
    localparam int WORD_BITS = 16;
    localparam logic [3:0] JMP_TOP = 4'hc;
    localparam int COND_MSB = 11;
    localparam int COND_LSB = 8;
    localparam int ABS_BIT = 7;
    localparam logic [3:0] CC_UC = 4'h0;
    localparam logic [3:0] CC_P = 4'h1;
    localparam logic [3:0] CC_LS = 4'h2;
    localparam logic [3:0] CC_HI = 4'h3;
    localparam logic [3:0] CC_LT = 4'h4;
    localparam logic [3:0] CC_GE = 4'h5;
    localparam logic [3:0] CC_LE = 4'h6;
    localparam logic [3:0] CC_GT = 4'h7;
    localparam logic [3:0] CC_C = 4'h8;
    localparam logic [3:0] CC_NC = 4'h9;
    localparam logic [3:0] CC_Z = 4'ha;
    localparam logic [3:0] CC_NZ = 4'hb;
    localparam logic [3:0] CC_V = 4'hc;
    localparam logic [3:0] CC_NV = 4'hd;
    localparam logic [3:0] CC_N = 4'he;
    localparam logic [3:0] CC_NN = 4'hf;
    // Opcode values, top fields only; low four bits select the register
    localparam logic [10:0] OP_RDST_HI = 11'h001;
    localparam logic [10:0] OP_INC_HI = 11'h081;
    // Machine-state counts: first figure cached, second adds this penalty
    localparam logic [3:0] MS_PENALTY = 4'h3;
    localparam logic [3:0] MS_SIMPLE = 4'h1;
    localparam logic [3:0] MS_ABS_T = 4'h3;
    localparam logic [3:0] MS_ABS_N = 4'h4;
    localparam logic [3:0] MS_REL_T = 4'h2;
    localparam logic [3:0] MS_REL_N = 4'h1;
    // Status word bit positions of the four flags
    localparam int ST_N = 31;
    localparam int ST_C = 30;
    localparam int ST_Z = 29;
    localparam int ST_V = 28;
    localparam logic [31:0] ST_RESET = 32'h0000_0010;
    localparam logic [31:0] PC_RESET = 32'h0000_0000;
    localparam logic [4:0] WB_PC = 5'h00;
    localparam logic [4:0] WB_ST = 5'h01;
    localparam logic [4:0] WB_REG0 = 5'h10;
    typedef enum logic [1:0] {BCE_IDLE, BCE_EXT1, BCE_EXT2, BCE_WAIT} bce_state_t;
endpackage

// >>> src/bce_cond_eval.sv
// Condition code evaluator for the conditional jumps
module bce_cond_eval (
    input wire logic [3:0] code,
    input wire logic n,
    input wire logic c,
    input wire logic z,
    input wire logic v,
    output logic taken
);
    import bce_pkg::*;
    always_comb begin
        case (code)
            CC_UC: taken = 1'b1;
            CC_P: taken = !n && !z;
            CC_LS: taken = c || z;
            CC_HI: taken = !c && !z;
            CC_LT: taken = n ^ v;
            CC_GE: taken = !(n ^ v);
            CC_LE: taken = (n ^ v) || z;
            CC_GT: taken = !(n ^ v) && !z;
            CC_C: taken = c;
            CC_NC: taken = !c;
            CC_Z: taken = z;
            CC_NZ: taken = !z;
            CC_V: taken = v;
            CC_NV: taken = !v;
            CC_N: taken = n;
            CC_NN: taken = !n;
            default: taken = 1'b0;
        endcase
    end
endmodule // bce_cond_eval

// >>> src/bce_inc_alu.sv
// Increment adder with flag generation
module bce_inc_alu #(
    parameter int W = 32
) (
    input wire logic [W-1:0] a,
    output logic [W-1:0] sum,
    output logic n,
    output logic c,
    output logic z,
    output logic v
);
    logic [W:0] full;
    assign full = {1'b0, a} + {{W{1'b0}}, 1'b1};
    assign sum = full[W-1:0];
    assign n = full[W-1];
    assign c = full[W];
    assign z = (full[W-1:0] == '0);
    // Adding +1 overflows only when a positive operand turns negative
    assign v = !a[W-1] && full[W-1];
endmodule // bce_inc_alu

// >>> tb/branch_condition_exec_test.sv
// Self-checking bench for the execution unit over its Wishbone port
module branch_condition_exec_test;
    timeunit 1ns;
    timeprecision 1ns;
    import bce_pkg::*;
    logic clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, busy;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i, last_states, f, code, pen, sts;
    logic [DATA_W-1:0] wb_dat_i, wb_dat_o;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic [31:0] pc_e, st_e, a, r, tgt, vals[6];
    logic [7:0] off8, radr;
    logic [15:0] off16;
    logic t;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;
    int rnd;

    bce_exec #(.NREGS(16)) bce_exec_inst (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy(busy),
        .last_states(last_states));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t read %h, expected %h", $time, seen, exp);
        end
    endtask

    // Hang guard; the whole run needs a few thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            complete_run();
        end
    end

    // Read data is valid with ack; oldest note belongs to this answer
    always @(posedge clk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
            check(wb_dat_o & msk_q.pop_front(), exp_q.pop_front());
        end
    end

    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] d,
                       input logic [3:0] sel);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        wb_sel_i <= sel;
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        bus(1'b1, adr, d, 4'hf);
    endtask

    task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input logic [31:0] msk);
        exp_q.push_back(exp);
        msk_q.push_back(msk);
        bus(1'b0, adr, 32'h0, 4'hf);
    endtask

    // Each issued word moves the sequential address on by one word
    task automatic issue(input logic [15:0] w);
        wr(8'h08, {16'h0, w});
        pc_e = pc_e + 32'h10;
    endtask

    function automatic logic cc(input logic [3:0] k, input logic [3:0] fl);
        logic n, c, z, v;
        {n, c, z, v} = fl;
        case (k)
            4'h0: cc = 1'b1;
            4'h1: cc = !n && !z;
            4'h2: cc = c || z;
            4'h3: cc = !c && !z;
            4'h4: cc = n ^ v;
            4'h5: cc = !(n ^ v);
            4'h6: cc = (n ^ v) || z;
            4'h7: cc = !(n ^ v) && !z;
            4'h8: cc = c;
            4'h9: cc = !c;
            4'ha: cc = z;
            4'hb: cc = !z;
            4'hc: cc = v;
            4'hd: cc = !v;
            4'he: cc = n;
            default: cc = !n;
        endcase
    endfunction

    initial begin
        reset = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        rnd = $urandom(32'h5462);
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        rd(8'h00, PC_RESET, 32'hffff_ffff);
        rd(8'h04, ST_RESET, 32'hffff_ffff);
        rd(8'h40, 32'h0, 32'hffff_ffff);
        rd(8'h0c, 32'h0, 32'h1f);
        wr(8'h20, $urandom());
        rd(8'h20, 32'h0, 32'hffff_ffff);
        rd(8'h08, 32'h0, 32'hffff_ffff);
        wr(8'h00, 32'h1234_567f);
        bus(1'b1, 8'h00, 32'hffff_ffff, 4'h3);
        rd(8'h00, 32'h1234_5670, 32'hffff_ffff);
        pc_e = 32'h1234_5670;
        for (int m = 0; m < 2; m++) begin
            wr(8'h0c, {25'h0, m[0], 6'h0});
            pen = m[0] ? MS_PENALTY : 4'h0;
            st_e = {4'($urandom()), 28'h10};
            wr(8'h04, st_e);
            radr = 8'h40 + {2'h0, 4'(m * 7 + 3), 2'h0};
            issue(16'h0020 | 16'(m * 7 + 3));
            rd(radr, st_e, 32'hffff_ffff);
            rd(8'h04, st_e, 32'hffff_ffff);
            rd(8'h0c, {25'h0, m[0], 2'h0, 4'h1 + pen}, 32'h5f);
        end
        vals = '{32'h0, 32'hf, 32'hffff_ffff, 32'hffff_fffe, 32'h7fff_ffff, $urandom()};
        for (int i = 0; i < 6; i++) begin
            wr(8'h0c, {25'h0, i[0], 6'h0});
            pen = i[0] ? MS_PENALTY : 4'h0;
            a = vals[i];
            r = a + 32'h1;
            radr = 8'h40 + {2'h0, 4'(i + 5), 2'h0};
            wr(radr, a);
            wr(8'h04, ST_RESET);
            issue(16'h1020 | 16'(i + 5));
            rd(radr, r, 32'hffff_ffff);
            rd(8'h04, {r[31], a == 32'hffff_ffff, r == 32'h0, a == 32'h7fff_ffff, 28'h10},
               32'hffff_ffff);
            rd(8'h0c, {25'h0, i[0], 2'h0, 4'h1 + pen}, 32'h5f);
        end
        // Flags left by an increment steer the very next jump, twice over
        wr(8'h44, 32'hffff_ffff);
        wr(8'h00, 32'h0000_1000);
        issue(16'h1021);
        issue({JMP_TOP, CC_Z, 8'h02});
        rd(8'h00, 32'h0000_1040, 32'hffff_ffff);
        issue(16'h1021);
        issue({JMP_TOP, CC_Z, 8'h02});
        rd(8'h00, 32'h0000_1060, 32'hffff_ffff);
        // Rounds: short relative twice, absolute twice, long relative once
        for (int k = 0; k < 80; k++) begin
            code = 4'(k);
            if (k % 16 == 0) begin
                wr(8'h0c, {25'h0, (k / 16) % 2 == 1, 6'h0});
                pen = ((k / 16) % 2 == 1) ? MS_PENALTY : 4'h0;
            end
            f = 4'($urandom());
            st_e = {f, 28'h10};
            wr(8'h04, st_e);
            pc_e = $urandom() & 32'hffff_fff0;
            wr(8'h00, pc_e);
            t = cc(code, f);
            if (k < 32) begin
                off8 = 8'($urandom());
                if (off8 == 8'h0 || off8 == 8'h80) off8 = 8'h81;
                issue({JMP_TOP, code, off8});
                tgt = t ? pc_e + {{20{off8[7]}}, off8, 4'h0} : pc_e;
                sts = (t ? MS_REL_T : MS_REL_N) + pen;
            end else if (k < 64) begin
                issue({JMP_TOP, code, 8'h80});
                rd(8'h0c, 32'h10, 32'h10);
                check({31'h0, busy}, 32'h1);
                a = $urandom();
                issue(a[15:0]);
                issue(a[31:16]);
                tgt = t ? {a[31:4], 4'h0} : pc_e;
                sts = (t ? MS_ABS_T : MS_ABS_N) + pen;
            end else begin
                issue({JMP_TOP, code, 8'h00});
                off16 = 16'($urandom());
                issue(off16);
                tgt = t ? pc_e + {{12{off16[15]}}, off16, 4'h0} : pc_e;
            end
            rd(8'h00, tgt, 32'hffff_ffff);
            rd(8'h04, st_e, 32'hffff_ffff);
            if (k < 64) rd(8'h0c, {28'h0, sts}, 32'h1f);
            if (k < 64) check({28'h0, last_states}, {28'h0, sts});
        end
        repeat (2) @(posedge clk);
        complete_run();
    end
endmodule // branch_condition_exec_test
